/* core/frt_clk_gen.sv */
/*
 count pulse generator: prescaler, source select, falling-edge pulse.
 assumes ext_level is already synchronised to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module frt_clk_gen
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] clock_sel,
    input wire logic ext_level,
    output logic count_pulse
);
    import frt_pkg::*;

    logic [`PRE_WIDTH-1:0] pre_reg;
    logic src_level;
    logic src_prev_reg;

    always_ff @(posedge clock)
    begin
        if (rst)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 1'b1;
    end

    // external source counts on the rising edge, so it is inverted here
    always_comb
    begin
        unique case (clock_sel)
            2'b00: src_level = pre_reg[`PRE_BIT_DIV2];
            2'b01: src_level = pre_reg[`PRE_BIT_DIV8];
            2'b10: src_level = pre_reg[`PRE_BIT_DIV32];
            2'b11: src_level = ~ext_level;
        endcase
    end

    // edge is taken on the selected level, so a select change from high to low
    // also reads as a falling edge and counts once
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            src_prev_reg <= 1'b0;
            count_pulse <= 1'b0;
        end
        else
        begin
            src_prev_reg <= src_level;
            count_pulse <= src_prev_reg & ~src_level;
        end
    end
endmodule // frt_clk_gen
`default_nettype wire

/* core/frt_params.svh */
/*
 constants for the free-running timer: register offsets, field positions, reset values.
 assumes inclusion by bare name from the package and the sim modules.
*/
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

// byte offsets on the 8-bit register port
`define OFS_COUNT_HI 4'h0
`define OFS_COUNT_LO 4'h1
`define OFS_CMP_A_HI 4'h2
`define OFS_CMP_A_LO 4'h3
`define OFS_CMP_B_HI 4'h4
`define OFS_CMP_B_LO 4'h5
`define OFS_CAP_HI 4'h6
`define OFS_CAP_LO 4'h7
`define OFS_TIMER_CTRL 4'h8
`define OFS_CTRL_STATUS 4'h9
`define OFS_IRQ_STATUS 4'ha
`define OFS_IRQ_MASK 4'hb

// timer_ctrl_status fields
`define BIT_CAPTURE_FLAG 7
`define BIT_MATCH_FLAG_B 6
`define BIT_MATCH_FLAG_A 5
`define BIT_ROLLOVER_FLAG 4
`define BIT_OUT_LEVEL_B 3
`define BIT_OUT_LEVEL_A 2
`define BIT_CAPTURE_EDGE_SEL 1
`define BIT_CLEAR_ON_MATCH_A 0

// timer_ctrl fields: enables in 7..4, clock select in 1..0
`define BIT_EN_CAPTURE 7
`define BIT_EN_MATCH_B 6
`define BIT_EN_MATCH_A 5
`define BIT_EN_ROLLOVER 4
`define BIT_CLOCK_SEL_HI 1
`define BIT_CLOCK_SEL_LO 0

`define RST_COUNT 16'h0000
`define RST_CMP 16'hffff
`define RST_CAPTURE 16'h0000
`define RST_BYTE 8'h00
`define COUNT_ALL_ONES 16'hffff

// prescaler halves: /2, /8, /32 toggle bits
`define PRE_BIT_DIV2 0
`define PRE_BIT_DIV8 2
`define PRE_BIT_DIV32 4
`define PRE_WIDTH 5

`endif

/* core/frt_pkg.sv */
/*
 types shared by the free-running timer modules.
 assumes frt_params.svh is on the include path.
*/
package frt_pkg;
    `include "frt_params.svh"

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef enum logic [3:0] {
        SRC_DIV2 = 4'b0001,
        SRC_DIV8 = 4'b0010,
        SRC_DIV32 = 4'b0100,
        SRC_EXT = 4'b1000
    } clk_src_e;

    typedef struct packed {
        logic capture;
        logic match_a;
        logic match_b;
        logic rollover;
    } irq_vec_s;
endpackage

/* core/frt_sync.sv */
/*
 two-flop synchroniser for one pin.
 assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module frt_sync
(
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic meta_reg;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_reg <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            meta_reg <= pin;
            level <= meta_reg;
        end
    end
endmodule // frt_sync
`default_nettype wire

/* core/frt_timer.sv */
/*
 16-bit free-running timer with two compare outputs, one capture input and rollover.
 assumes an 8-bit register port, upper byte accessed first, and pins asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module frt_timer
(
    input wire logic clock,
    input wire logic rst,
    input wire frt_pkg::bus_req_s bus,
    output logic [7:0] rdata,
    input wire logic capture_input,
    input wire logic ext_count_clk,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic capture_irq,
    output logic match_irq_a,
    output logic match_irq_b,
    output logic rollover_irq,
    output logic [1:0] irq_top,
    output logic irq
);
    import frt_pkg::*;

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] cmp_a_reg;
    logic [15:0] cmp_b_reg;
    logic [15:0] cap_reg;
    logic [7:0] latch_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] cs_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] flag_seen_reg;
    logic cap_level;
    logic cap_prev_reg;
    logic cap_pend_reg;
    logic ext_level;
    logic count_pulse;
    logic cap_edge;
    logic cap_strobe;
    logic hit_a;
    logic hit_b;
    logic match_a;
    logic match_b;
    logic clear_evt;
    logic wrap_evt;
    logic wr_count_lo;
    logic wr_cmp_a_lo;
    logic wr_cmp_b_lo;
    logic rd_cap_hi;
    logic [3:0] events;
    irq_vec_s req;

    function automatic logic is_wr(input bus_req_s b, input logic [3:0] ofs);
        is_wr = b.wr && (b.addr == ofs);
    endfunction

    function automatic logic is_rd(input bus_req_s b, input logic [3:0] ofs);
        is_rd = b.rd && (b.addr == ofs);
    endfunction

    function automatic logic [15:0] commit16(input logic [7:0] hi, input logic [7:0] lo);
        commit16 = {hi, lo};
    endfunction

    frt_sync u_sync_cap
    (
        .clock(clock),
        .rst(rst),
        .pin(capture_input),
        .level(cap_level)
    );

    frt_sync u_sync_ext
    (
        .clock(clock),
        .rst(rst),
        .pin(ext_count_clk),
        .level(ext_level)
    );

    frt_clk_gen u_clk_gen
    (
        .clock(clock),
        .rst(rst),
        .clock_sel(ctrl_reg[`BIT_CLOCK_SEL_HI:`BIT_CLOCK_SEL_LO]),
        .ext_level(ext_level),
        .count_pulse(count_pulse)
    );

    // bus decode, compare matches and event strobes
    always_comb
    begin
        wr_count_lo = is_wr(bus, `OFS_COUNT_LO);
        wr_cmp_a_lo = is_wr(bus, `OFS_CMP_A_LO);
        wr_cmp_b_lo = is_wr(bus, `OFS_CMP_B_LO);
        rd_cap_hi = is_rd(bus, `OFS_CAP_HI);
        hit_a = (count_reg == cmp_a_reg);
        hit_b = (count_reg == cmp_b_reg);
        match_a = hit_a && !wr_cmp_a_lo;
        match_b = hit_b && !wr_cmp_b_lo;
        clear_evt = match_a && cs_reg[`BIT_CLEAR_ON_MATCH_A];
        wrap_evt = count_pulse && !clear_evt && !wr_count_lo
            && (count_reg == `COUNT_ALL_ONES);
        if (cs_reg[`BIT_CAPTURE_EDGE_SEL])
            cap_edge = cap_level && !cap_prev_reg;
        else
            cap_edge = !cap_level && cap_prev_reg;
        cap_strobe = (cap_edge || cap_pend_reg) && !rd_cap_hi;
        events = {cap_strobe, match_b, match_a, wrap_evt};
    end

    // clear beats the low-byte write, which beats a pulse
    always_comb
    begin
        if (clear_evt)
            count_next = `RST_COUNT;
        else if (wr_count_lo)
            count_next = commit16(latch_reg, bus.wdata);
        else if (count_pulse)
            count_next = count_reg + 16'h0001;
        else
            count_next = count_reg;
    end

    // free-running count
    always_ff @(posedge clock)
    begin
        if (rst)
            count_reg <= `RST_COUNT;
        else
            count_reg <= count_next;
    end

    // capture edge detect and one-cycle postponement
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cap_prev_reg <= 1'b0;
            cap_pend_reg <= 1'b0;
        end
        else
        begin
            cap_prev_reg <= cap_level;
            cap_pend_reg <= (cap_edge || cap_pend_reg) && rd_cap_hi;
        end
    end

    // capture register loads on the strobe
    always_ff @(posedge clock)
    begin
        if (rst)
            cap_reg <= `RST_CAPTURE;
        else if (cap_strobe)
            cap_reg <= count_reg;
    end

    // byte latch: upper writes and upper reads of count and capture
    always_ff @(posedge clock)
    begin
        if (rst)
            latch_reg <= `RST_BYTE;
        else if (bus.wr && !bus.addr[0] && bus.addr < `OFS_TIMER_CTRL)
            latch_reg <= bus.wdata;
        else if (is_rd(bus, `OFS_COUNT_HI))
            latch_reg <= count_reg[7:0];
        else if (rd_cap_hi)
            latch_reg <= cap_reg[7:0];
    end

    // compare registers commit both bytes on the low write
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cmp_a_reg <= `RST_CMP;
            cmp_b_reg <= `RST_CMP;
        end
        else
        begin
            if (wr_cmp_a_lo)
                cmp_a_reg <= commit16(latch_reg, bus.wdata);
            if (wr_cmp_b_lo)
                cmp_b_reg <= commit16(latch_reg, bus.wdata);
        end
    end

    // enables and clock select
    always_ff @(posedge clock)
    begin
        if (rst)
            ctrl_reg <= `RST_BYTE;
        else if (is_wr(bus, `OFS_TIMER_CTRL))
            ctrl_reg <= bus.wdata;
    end

    // control bits written directly; flags set by hardware, cleared by a write of zero after a read of one
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cs_reg <= `RST_BYTE;
            flag_seen_reg <= 4'h0;
        end
        else
        begin
            if (is_wr(bus, `OFS_CTRL_STATUS))
            begin
                cs_reg[3:0] <= bus.wdata[3:0];
                // an event in the clearing cycle keeps its flag set
                cs_reg[7:4] <= (cs_reg[7:4] & ~(flag_seen_reg & ~bus.wdata[7:4]))
                    | events;
                flag_seen_reg <= 4'h0;
            end
            else
            begin
                cs_reg[7:4] <= cs_reg[7:4] | events;
                if (is_rd(bus, `OFS_CTRL_STATUS))
                    flag_seen_reg <= cs_reg[7:4];
            end
        end
    end

    // compare pins follow level bits on each match
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end
        else
        begin
            if (match_a)
                wave_out_a <= cs_reg[`BIT_OUT_LEVEL_A];
            if (match_b)
                wave_out_b <= cs_reg[`BIT_OUT_LEVEL_B];
        end
    end

    always_comb
    begin
        req.capture = cs_reg[`BIT_CAPTURE_FLAG] && ctrl_reg[`BIT_EN_CAPTURE];
        req.match_a = cs_reg[`BIT_MATCH_FLAG_A] && ctrl_reg[`BIT_EN_MATCH_A];
        req.match_b = cs_reg[`BIT_MATCH_FLAG_B] && ctrl_reg[`BIT_EN_MATCH_B];
        req.rollover = cs_reg[`BIT_ROLLOVER_FLAG] && ctrl_reg[`BIT_EN_ROLLOVER];
    end

    // request lines and highest pending source, registered
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            capture_irq <= 1'b0;
            match_irq_a <= 1'b0;
            match_irq_b <= 1'b0;
            rollover_irq <= 1'b0;
            irq_top <= 2'b00;
        end
        else
        begin
            capture_irq <= req.capture;
            match_irq_a <= req.match_a;
            match_irq_b <= req.match_b;
            rollover_irq <= req.rollover;
            if (req.capture)
                irq_top <= 2'b00;
            else if (req.match_a)
                irq_top <= 2'b01;
            else if (req.match_b)
                irq_top <= 2'b10;
            else
                irq_top <= 2'b11;
        end
    end

    // summary interrupt: sticky bits cleared by reading, masked onto irq
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (is_rd(bus, `OFS_IRQ_STATUS))
                irq_stat_reg <= events;
            else
                irq_stat_reg <= irq_stat_reg | events;
            if (is_wr(bus, `OFS_IRQ_MASK))
                irq_mask_reg <= bus.wdata[3:0];
            irq <= |((irq_stat_reg | events) & irq_mask_reg);
        end
    end

    // read answer stands only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (rst)
            rdata <= `RST_BYTE;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                `OFS_COUNT_HI: rdata <= count_reg[15:8];
                `OFS_COUNT_LO: rdata <= latch_reg;
                `OFS_CMP_A_HI: rdata <= cmp_a_reg[15:8];
                `OFS_CMP_A_LO: rdata <= cmp_a_reg[7:0];
                `OFS_CMP_B_HI: rdata <= cmp_b_reg[15:8];
                `OFS_CMP_B_LO: rdata <= cmp_b_reg[7:0];
                `OFS_CAP_HI: rdata <= cap_reg[15:8];
                `OFS_CAP_LO: rdata <= latch_reg;
                `OFS_TIMER_CTRL: rdata <= ctrl_reg;
                `OFS_CTRL_STATUS: rdata <= cs_reg;
                `OFS_IRQ_STATUS: rdata <= {4'h0, irq_stat_reg};
                `OFS_IRQ_MASK: rdata <= {4'h0, irq_mask_reg};
                default: rdata <= `RST_BYTE;
            endcase
        end
        else
            rdata <= `RST_BYTE;
    end
endmodule // frt_timer
`default_nettype wire

/* sim/frt_timer_checker.sv */
/*
 port checker for frt_timer: interrupt priority, enables, read answers, compare pins.
 assumes it is bound to frt_timer from the bench top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module frt_timer_checker
(
    input wire logic clock,
    input wire logic rst,
    input wire frt_pkg::bus_req_s bus,
    input wire logic [7:0] rdata,
    input wire logic wave_out_a,
    input wire logic wave_out_b,
    input wire logic capture_irq,
    input wire logic match_irq_a,
    input wire logic match_irq_b,
    input wire logic rollover_irq,
    input wire logic [1:0] irq_top,
    input wire logic irq
);
    import frt_pkg::*;
    logic [3:0] en_reg;
    logic [3:0] mask_reg;
    logic [2:0] since_wr_reg;
    wire logic [3:0] lines = {capture_irq, match_irq_b, match_irq_a, rollover_irq};
    // mirrors of the enable and mask bytes seen on the bus
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            en_reg <= 4'h0;
            mask_reg <= 4'h0;
        end
        else if (bus.wr && bus.addr == `OFS_TIMER_CTRL)
            en_reg <= bus.wdata[7:4];
        else if (bus.wr && bus.addr == `OFS_IRQ_MASK)
            mask_reg <= bus.wdata[3:0];
    end
    // cycles since the last control write, saturating
    always_ff @(posedge clock)
    begin
        if (rst)
            since_wr_reg <= 3'h7;
        else if (bus.wr && (bus.addr == `OFS_TIMER_CTRL || bus.addr == `OFS_CTRL_STATUS))
            since_wr_reg <= 3'h0;
        else if (since_wr_reg != 3'h7)
            since_wr_reg <= since_wr_reg + 3'h1;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence flag_a_up;
        ##[0:3] match_irq_a;
    endsequence
    sequence flag_b_up;
        ##[0:3] match_irq_b;
    endsequence
    a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_unmapped_read_zero: assert property (bus.rd && bus.addr >= 4'hc |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_top_capture: assert property (capture_irq |-> irq_top == 2'h0)
        else $error("capture not top request");
    a_top_match_a: assert property (!capture_irq && match_irq_a |-> irq_top == 2'h1)
        else $error("match a not top request");
    a_top_match_b: assert property (lines[3:1] == 3'b010 |-> irq_top == 2'h2)
        else $error("match b not top request");
    a_top_low_code: assert property (!$past(rst) && lines[3:1] == 3'b000 |-> irq_top == 2'h3)
        else $error("low request code wrong");
    a_lines_need_enable: assert property ((lines & ~$past(en_reg)) == 4'h0)
        else $error("request line without enable");
    a_irq_needs_mask: assert property (irq |-> $past(mask_reg) != 4'h0)
        else $error("interrupt with all masked");
    a_flag_soft_clear: assert property (|($past(lines) & ~lines) |-> since_wr_reg <= 3'h3)
        else $error("request dropped without a control write");
    a_wave_a_match: assert property ($changed(wave_out_a) && en_reg[1] |-> flag_a_up)
        else $error("pin a moved without match a");
    a_wave_b_match: assert property ($changed(wave_out_b) && en_reg[2] |-> flag_b_up)
        else $error("pin b moved without match b");
endmodule // frt_timer_checker
`default_nettype wire

/* sim/frt_timer_tb_top.sv */
/*
 testbench for frt_timer: reset values, count rates, byte latch, compare, rollover, capture.
 assumes host_cpu drives the register port and the checker is bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module frt_timer_tb_top;
    import frt_pkg::*;
    typedef struct packed { logic [3:0] a; logic [7:0] e; } rd_row_s;
    typedef struct packed { logic [1:0] sel; logic [7:0] lo; logic [7:0] hi; } rate_row_s;
    logic clock, rst, capture_input, ext_count_clk, wave_out_a, wave_out_b, irq;
    logic capture_irq, match_irq_a, match_irq_b, rollover_irq;
    logic [1:0] irq_top;
    logic [7:0] rdata, d;
    logic [15:0] v, w;
    bus_req_s bus;
    int mismatches, n_compared, cycles;
    rd_row_s rd_rows [12] = '{'{4'h2, 8'hff}, '{4'h3, 8'hff}, '{4'h4, 8'hff}, '{4'h5, 8'hff},
        '{4'h6, 8'h00}, '{4'h7, 8'h00}, '{4'h8, 8'h00}, '{4'h9, 8'h00},
        '{4'ha, 8'h00}, '{4'hb, 8'h00}, '{4'hc, 8'h00}, '{4'hf, 8'h00}};
    rate_row_s rate_rows [4] = '{'{2'h0, 8'h51, 8'h54}, '{2'h1, 8'h13, 8'h16},
        '{2'h2, 8'h04, 8'h06}, '{2'h3, 8'h0f, 8'h12}};
    frt_timer frt_timer_i
    (
        .clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .capture_input(capture_input),
        .ext_count_clk(ext_count_clk), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .capture_irq(capture_irq), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
        .rollover_irq(rollover_irq), .irq_top(irq_top), .irq(irq)
    );
    host_cpu host_cpu_i
    (
        .clock(clock), .bus(bus), .rdata(rdata)
    );
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial
    begin
        ext_count_clk = 1'b0;
        forever
        begin
            repeat (5) @(posedge clock);
            ext_count_clk <= ~ext_count_clk;
        end
    end
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        rst = 1'b1;
        capture_input = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        foreach (rd_rows[i])
        begin
            host_cpu_i.rd(rd_rows[i].a, d);
            chk({8'h00, d}, {8'h00, rd_rows[i].e});
        end
        foreach (rate_rows[i])
        begin
            host_cpu_i.wr(`OFS_TIMER_CTRL, {6'h00, rate_rows[i].sel});
            host_cpu_i.rd16(`OFS_COUNT_HI, v);
            repeat (160) @(posedge clock);
            host_cpu_i.rd16(`OFS_COUNT_HI, w);
            w = w - v;
            chk({15'h0, w >= {8'h00, rate_rows[i].lo} && w <= {8'h00, rate_rows[i].hi}}, 16'h1);
        end
        $display("test table done");
        host_cpu_i.wr(`OFS_CMP_A_HI, 8'h12);
        host_cpu_i.rd(`OFS_CMP_A_HI, d);
        chk({8'h00, d}, 16'h00ff);
        host_cpu_i.wr(`OFS_CMP_A_LO, 8'h34);
        host_cpu_i.rd16(`OFS_CMP_A_HI, v);
        chk(v, 16'h1234);
        host_cpu_i.wr(`OFS_TIMER_CTRL, 8'h02);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'haa55);
        host_cpu_i.rd16(`OFS_COUNT_HI, v);
        chk({15'h0, v == 16'haa55 || v == 16'haa56}, 16'h1);
        $display("test byte_latch done");
        host_cpu_i.wr(`OFS_TIMER_CTRL, 8'h60);
        host_cpu_i.wr16(`OFS_CMP_A_HI, 16'h8000);
        host_cpu_i.wr16(`OFS_CMP_B_HI, 16'h0020);
        host_cpu_i.wr(`OFS_CTRL_STATUS, 8'h0d);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'h0000);
        repeat (100) @(posedge clock);
        host_cpu_i.rd16(`OFS_COUNT_HI, v);
        chk({15'h0, v > 16'h0020}, 16'h1);
        chk({10'h0, match_irq_a, wave_out_a, match_irq_b, wave_out_b, irq_top}, 16'h000e);
        host_cpu_i.wr16(`OFS_CMP_A_HI, 16'h0010);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'h0000);
        repeat (60) @(posedge clock);
        host_cpu_i.rd16(`OFS_COUNT_HI, v);
        chk({15'h0, v <= 16'h0010}, 16'h1);
        chk({14'h0, wave_out_a, irq_top == 2'h1}, 16'h0003);
        host_cpu_i.rd(`OFS_CTRL_STATUS, d);
        host_cpu_i.wr(`OFS_CTRL_STATUS, (d & 8'h0f) ^ 8'h04);
        repeat (40) @(posedge clock);
        chk({15'h0, wave_out_a}, 16'h0000);
        host_cpu_i.wr16(`OFS_CMP_A_HI, 16'h0000);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'h0000);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'h0055);
        host_cpu_i.rd16(`OFS_COUNT_HI, v);
        chk(v, 16'h0000);
        host_cpu_i.wr16(`OFS_CMP_A_HI, 16'h0010);
        $display("test compare done");
        host_cpu_i.wr(`OFS_TIMER_CTRL, 8'h12);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'h8000);
        host_cpu_i.clear_flags();
        host_cpu_i.rd(`OFS_IRQ_STATUS, d);
        host_cpu_i.wr(`OFS_IRQ_MASK, 8'h01);
        host_cpu_i.wr16(`OFS_COUNT_HI, 16'hffff);
        repeat (40) @(posedge clock);
        chk({12'h0, rollover_irq, irq_top, irq}, 16'h000f);
        host_cpu_i.rd(`OFS_IRQ_STATUS, d);
        chk({8'h00, d}, 16'h0001);
        host_cpu_i.rd(`OFS_IRQ_STATUS, d);
        chk({7'h00, irq, d}, 16'h0000);
        host_cpu_i.wr(`OFS_CTRL_STATUS, 8'h00);
        repeat (3) @(posedge clock);
        chk({15'h0, rollover_irq}, 16'h0001);
        host_cpu_i.clear_flags();
        repeat (3) @(posedge clock);
        chk({15'h0, rollover_irq}, 16'h0000);
        $display("test rollover done");
        host_cpu_i.wr(`OFS_TIMER_CTRL, 8'h82);
        @(posedge clock);
        capture_input <= 1'b1;
        repeat (8) @(posedge clock);
        chk({15'h0, capture_irq}, 16'h0000);
        host_cpu_i.wr(`OFS_CTRL_STATUS, 8'h02);
        @(posedge clock);
        capture_input <= 1'b0;
        repeat (8) @(posedge clock);
        chk({15'h0, capture_irq}, 16'h0000);
        capture_input <= 1'b1;
        repeat (8) @(posedge clock);
        chk({12'h0, capture_irq, irq_top, irq}, 16'h0008);
        host_cpu_i.rd16(`OFS_CAP_HI, v);
        host_cpu_i.rd16(`OFS_COUNT_HI, w);
        chk({15'h0, w - v <= 16'h0001}, 16'h1);
        $display("test capture done");
        stop_test();
    end
endmodule // frt_timer_tb_top
bind frt_timer frt_timer_checker frt_timer_checker_i
(
    .clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .capture_irq(capture_irq), .match_irq_a(match_irq_a),
    .match_irq_b(match_irq_b), .rollover_irq(rollover_irq), .irq_top(irq_top), .irq(irq)
);
`default_nettype wire

/* sim/host_cpu.sv */
/*
 host cpu model: byte master on the timer register port.
 assumes the timer clock; the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module host_cpu
(
    input wire logic clock,
    output var frt_pkg::bus_req_s bus,
    input wire logic [7:0] rdata
);
    import frt_pkg::*;
    initial bus = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a | 4'h1, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a | 4'h1, v[7:0]);
    endtask
    task automatic clear_flags;
        logic [7:0] s;
        rd(`OFS_CTRL_STATUS, s);
        wr(`OFS_CTRL_STATUS, s & 8'h0f);
    endtask
endmodule // host_cpu
`default_nettype wire
